// >>> pkg/nv_clock_pkg.sv
// Constants shared by the nonvolatile timekeeping memory.
package nv_clock_pkg;
    localparam int unsigned ADDR_W = 19;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned MEM_DEPTH = 524288;
    localparam int unsigned CLOCK_REGION_BITS = 3;

    // Clock register indices within the top eight locations.
    localparam logic [2:0] CTRL_IDX = 3'h0;
    localparam logic [2:0] SEC_IDX = 3'h1;
    localparam logic [2:0] MIN_IDX = 3'h2;
    localparam logic [2:0] HOUR_IDX = 3'h3;
    localparam logic [2:0] WDAY_IDX = 3'h4;
    localparam logic [2:0] DATE_IDX = 3'h5;
    localparam logic [2:0] MONTH_IDX = 3'h6;
    localparam logic [2:0] YEAR_IDX = 3'h7;

    // Control and function bit positions.
    localparam int unsigned WRITE_HOLD_BIT = 7;
    localparam int unsigned READ_HOLD_BIT = 6;
    localparam int unsigned OSC_HALT_BIT = 7;
    localparam int unsigned FREQ_TEST_BIT = 6;

    // Counter-owned bits of each clock register; other bits are plain memory.
    localparam logic [7:0] SEC_MASK = 8'h7f;
    localparam logic [7:0] MIN_MASK = 8'h7f;
    localparam logic [7:0] HOUR_MASK = 8'h3f;
    localparam logic [7:0] WDAY_MASK = 8'h07;
    localparam logic [7:0] DATE_MASK = 8'h3f;
    localparam logic [7:0] MONTH_MASK = 8'h1f;
    localparam logic [7:0] YEAR_MASK = 8'hff;

    // BCD limits.
    localparam logic [7:0] SEC_LAST = 8'h59;
    localparam logic [7:0] MIN_LAST = 8'h59;
    localparam logic [7:0] HOUR_LAST = 8'h23;
    localparam logic [7:0] WDAY_LAST = 8'h07;
    localparam logic [7:0] MONTH_LAST = 8'h12;
    localparam logic [7:0] YEAR_LAST = 8'h99;
    localparam logic [7:0] ZERO_FIRST = 8'h00;
    localparam logic [7:0] ONE_FIRST = 8'h01;

    // Reset values of the counters and the visible registers.
    localparam logic [7:0] RESET_TIME = 8'h00;
    localparam logic [7:0] RESET_DAY = 8'h01;

    // Time base.
    localparam int unsigned CLOCK_HZ = 40000000;
    localparam int unsigned TEST_HZ = 512;
    localparam int unsigned TEST_DIV_CYCLES = CLOCK_HZ / TEST_HZ;
    localparam logic [8:0] TEST_TICKS_LAST = 9'h1ff;
endpackage

// >>> logic/nv_timekeeping_ram_clock.sv
// Byte-wide memory whose top eight locations hold a double-buffered BCD clock.
//
// Behaviour
// - 512k by 8 memory, clock in top eight
// - BCD time and date, 24-hour hours
// - Month length and leap years handled automatically
// - Visible registers buffered, counters stall only on oscillator halt
// - Low supply blocks accesses, floats data
// - Read hold freezes visible register updates
// - Held registers show time at hold
// - Clearing read hold refreshes within one second
// - Write hold stops updates for loading
// - Clearing write hold loads the counters
// - Seconds MSB halts or runs oscillator
// - Weekday bit 6 toggles seconds LSB
// - Continuous seconds read shows test toggle
// - Enable pins select deselect, write, read
// - Unassigned clock bits act as memory
// - Power-fail output low while supply low
`timescale 1ns/1ps
`default_nettype none

module nv_timekeeping_ram_clock #(
    parameter int unsigned TEST_DIV = nv_clock_pkg::TEST_DIV_CYCLES
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic resetn,
    // Memory bus pins.
    input wire logic [nv_clock_pkg::ADDR_W-1:0] address,
    input wire logic chip_enable_n,
    input wire logic output_enable_n,
    input wire logic write_enable_n,
    input wire logic [nv_clock_pkg::DATA_W-1:0] data_in,
    output logic [nv_clock_pkg::DATA_W-1:0] data_out,
    output logic data_oe_n,
    // Supply supervision.
    input wire logic supply_ok,
    output logic power_fail_out_n
);
    import nv_clock_pkg::*;

    function automatic logic [7:0] field_mask(input logic [2:0] idx);
        unique case (idx)
            SEC_IDX: field_mask = SEC_MASK;
            MIN_IDX: field_mask = MIN_MASK;
            HOUR_IDX: field_mask = HOUR_MASK;
            WDAY_IDX: field_mask = WDAY_MASK;
            DATE_IDX: field_mask = DATE_MASK;
            MONTH_IDX: field_mask = MONTH_MASK;
            YEAR_IDX: field_mask = YEAR_MASK;
            default: field_mask = 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] last,
                                           input logic [7:0] first);
        if (v >= last) begin
            bcd_inc = first;
        end else if (v[3:0] >= 4'h9) begin
            bcd_inc = {4'(v[7:4] + 4'h1), 4'h0};
        end else begin
            bcd_inc = 8'(v + 8'h01);
        end
    endfunction

    // Year 00 counts as leap, which holds for 2000 and every year up to 2099.
    function automatic logic [7:0] month_last(input logic [7:0] month, input logic [7:0] year);
        logic leap;
        leap = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6)
                       : (year[3:0] == 4'h0 || year[3:0] == 4'h4 || year[3:0] == 4'h8);
        unique case (month)
            8'h02: month_last = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: month_last = 8'h30;
            default: month_last = 8'h31;
        endcase
    endfunction

    // True for the eight uppermost locations, where the clock registers live.
    function automatic logic in_clock_region(input logic [ADDR_W-1:0] addr);
        in_clock_region = &addr[ADDR_W-1:CLOCK_REGION_BITS];
    endfunction

    // Calendar fields that count from one come out of reset as 01, the rest as 00.
    function automatic logic [7:0] reset_value(input logic [2:0] idx);
        unique case (idx)
            WDAY_IDX, DATE_IDX, MONTH_IDX: reset_value = RESET_DAY;
            default: reset_value = RESET_TIME;
        endcase
    endfunction

    // Two-flop synchronisers for every pin input.
    logic [ADDR_W-1:0] addr_meta_reg, addr_sync_reg;
    logic [DATA_W-1:0] din_meta_reg, din_sync_reg;
    logic [3:0] ctl_meta_reg, ctl_sync_reg;
    always_ff @(posedge clock) begin
        if (!resetn) begin
            addr_meta_reg <= '0;
            addr_sync_reg <= '0;
            din_meta_reg <= '0;
            din_sync_reg <= '0;
            // Supply reads as good in reset, so the power-fail pin does not pulse on release.
            ctl_meta_reg <= 4'hf;
            ctl_sync_reg <= 4'hf;
        end else begin
            addr_meta_reg <= address;
            addr_sync_reg <= addr_meta_reg;
            din_meta_reg <= data_in;
            din_sync_reg <= din_meta_reg;
            ctl_meta_reg <= {supply_ok, chip_enable_n, output_enable_n, write_enable_n};
            ctl_sync_reg <= ctl_meta_reg;
        end
    end

    logic ok_s, ce_s, oe_s, we_s;
    assign {ok_s, ce_s, oe_s, we_s} = ctl_sync_reg;

    // Access decode and write capture.
    logic write_act, read_drive;
    logic wr_prev_reg, wr_prev_next;
    logic [ADDR_W-1:0] wr_addr_reg, wr_addr_next;
    logic [DATA_W-1:0] wr_data_reg, wr_data_next;
    logic commit;
    logic commit_clock;
    logic [2:0] commit_idx;

    assign write_act = ok_s && !ce_s && !we_s;
    assign read_drive = ok_s && !ce_s && we_s && !oe_s;
    // A write lands at its end; a supply drop mid-cycle discards it.
    assign commit = wr_prev_reg && !write_act && ok_s;
    assign commit_clock = in_clock_region(wr_addr_reg);
    assign commit_idx = wr_addr_reg[CLOCK_REGION_BITS-1:0];

    always_comb begin
        wr_prev_next = write_act;
        wr_addr_next = write_act ? addr_sync_reg : wr_addr_reg;
        wr_data_next = write_act ? din_sync_reg : wr_data_reg;
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            wr_prev_reg <= 1'b0;
            wr_addr_reg <= '0;
            wr_data_reg <= '0;
        end else begin
            wr_prev_reg <= wr_prev_next;
            wr_addr_reg <= wr_addr_next;
            wr_data_reg <= wr_data_next;
        end
    end

    // Plain memory below the clock registers.
    logic [DATA_W-1:0] mem [0:MEM_DEPTH-1];
    always_ff @(posedge clock) begin
        if (commit && !commit_clock) begin
            mem[wr_addr_reg] <= wr_data_reg;
        end
    end

    // Visible registers, internal counters and the time base.
    logic [7:0] vis_reg [0:7];
    logic [7:0] vis_next [0:7];
    logic [7:0] cnt_reg [1:7];
    logic [7:0] cnt_next [1:7];
    logic [31:0] pre_reg, pre_next;
    logic [8:0] sub_reg, sub_next;
    logic ft_phase_reg, ft_phase_next;
    logic osc_run, test_tick, sec_tick, hold, wr_release;

    assign osc_run = !vis_reg[SEC_IDX][OSC_HALT_BIT];
    assign test_tick = osc_run && (pre_reg >= TEST_DIV - 1);
    assign sec_tick = test_tick && (sub_reg == TEST_TICKS_LAST);
    assign hold = vis_reg[CTRL_IDX][WRITE_HOLD_BIT] || vis_reg[CTRL_IDX][READ_HOLD_BIT];
    assign wr_release = commit && commit_clock && commit_idx == CTRL_IDX
                        && vis_reg[CTRL_IDX][WRITE_HOLD_BIT] && !wr_data_reg[WRITE_HOLD_BIT];

    always_comb begin
        pre_next = pre_reg;
        sub_next = sub_reg;
        ft_phase_next = ft_phase_reg;
        if (osc_run) begin
            pre_next = test_tick ? 32'h0 : 32'(pre_reg + 32'h1);
            if (test_tick) begin
                sub_next = 9'(sub_reg + 9'h1);
                ft_phase_next = !ft_phase_reg;
            end
        end
    end

    // Counters run regardless of host activity unless the oscillator is halted; a write-hold release reloads them.
    always_comb begin
        for (int i = 1; i <= 7; i++) begin
            cnt_next[i] = cnt_reg[i];
        end
        if (wr_release) begin
            for (int i = 1; i <= 7; i++) begin
                cnt_next[i] = vis_reg[i] & field_mask(3'(i));
            end
        end else if (sec_tick) begin
            cnt_next[SEC_IDX] = bcd_inc(cnt_reg[SEC_IDX], SEC_LAST, ZERO_FIRST);
            if (cnt_reg[SEC_IDX] >= SEC_LAST) begin
                cnt_next[MIN_IDX] = bcd_inc(cnt_reg[MIN_IDX], MIN_LAST, ZERO_FIRST);
                if (cnt_reg[MIN_IDX] >= MIN_LAST) begin
                    cnt_next[HOUR_IDX] = bcd_inc(cnt_reg[HOUR_IDX], HOUR_LAST, ZERO_FIRST);
                    if (cnt_reg[HOUR_IDX] >= HOUR_LAST) begin
                        cnt_next[WDAY_IDX] = bcd_inc(cnt_reg[WDAY_IDX], WDAY_LAST, ONE_FIRST);
                        cnt_next[DATE_IDX] = bcd_inc(cnt_reg[DATE_IDX],
                            month_last(cnt_reg[MONTH_IDX], cnt_reg[YEAR_IDX]),
                            ONE_FIRST);
                        if (cnt_reg[DATE_IDX] >=
                            month_last(cnt_reg[MONTH_IDX], cnt_reg[YEAR_IDX])) begin
                            cnt_next[MONTH_IDX] = bcd_inc(cnt_reg[MONTH_IDX], MONTH_LAST,
                                                          ONE_FIRST);
                            if (cnt_reg[MONTH_IDX] >= MONTH_LAST) begin
                                cnt_next[YEAR_IDX] = bcd_inc(cnt_reg[YEAR_IDX], YEAR_LAST,
                                                             ZERO_FIRST);
                            end
                        end
                    end
                end
            end
        end
    end

    // Visible copies refresh on each second unless held; unassigned bits keep host data.
    always_comb begin
        for (int i = 0; i <= 7; i++) begin
            vis_next[i] = vis_reg[i];
        end
        if (sec_tick && !hold) begin
            for (int i = 1; i <= 7; i++) begin
                vis_next[i] = (vis_reg[i] & ~field_mask(3'(i)))
                              | (cnt_next[i] & field_mask(3'(i)));
            end
        end
        if (commit && commit_clock) begin
            vis_next[commit_idx] = wr_data_reg;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            pre_reg <= 32'h0;
            sub_reg <= 9'h0;
            ft_phase_reg <= 1'b0;
            for (int i = 0; i <= 7; i++) begin
                vis_reg[i] <= reset_value(3'(i));
            end
            for (int i = 1; i <= 7; i++) begin
                cnt_reg[i] <= reset_value(3'(i));
            end
        end else begin
            pre_reg <= pre_next;
            sub_reg <= sub_next;
            ft_phase_reg <= ft_phase_next;
            for (int i = 0; i <= 7; i++) begin
                vis_reg[i] <= vis_next[i];
            end
            for (int i = 1; i <= 7; i++) begin
                cnt_reg[i] <= cnt_next[i];
            end
        end
    end

    // Read path and output pins.
    logic [DATA_W-1:0] rd_data;
    logic [DATA_W-1:0] data_out_reg, data_out_next;
    logic data_oe_n_reg, data_oe_n_next;
    logic pfo_n_reg, pfo_n_next;
    logic rd_clock;
    logic [2:0] rd_idx;

    assign rd_clock = in_clock_region(addr_sync_reg);
    assign rd_idx = addr_sync_reg[CLOCK_REGION_BITS-1:0];

    always_comb begin
        rd_data = rd_clock ? vis_reg[rd_idx] : mem[addr_sync_reg];
        // In frequency-test mode bit 0 of the seconds register shows the test phase.
        if (rd_clock && rd_idx == SEC_IDX && vis_reg[WDAY_IDX][FREQ_TEST_BIT] && osc_run) begin
            rd_data[0] = ft_phase_reg;
        end
        data_out_next = rd_data;
        data_oe_n_next = !read_drive;
        pfo_n_next = ok_s;
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            data_out_reg <= '0;
            data_oe_n_reg <= 1'b1;
            pfo_n_reg <= 1'b1;
        end else begin
            data_out_reg <= data_out_next;
            data_oe_n_reg <= data_oe_n_next;
            pfo_n_reg <= pfo_n_next;
        end
    end

    assign data_out = data_out_reg;
    assign data_oe_n = data_oe_n_reg;
    assign power_fail_out_n = pfo_n_reg;
endmodule

`default_nettype wire

// >>> tb/nv_clock_properties.sv
// Pin-level checks on the timekeeping memory.
`timescale 1ns/1ps
`default_nettype none
module nv_clock_properties #(
    parameter int unsigned TEST_DIV = 4
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic resetn,
    // Memory bus and supply pins.
    input wire logic [nv_clock_pkg::ADDR_W-1:0] address,
    input wire logic chip_enable_n,
    input wire logic output_enable_n,
    input wire logic write_enable_n,
    input wire logic [nv_clock_pkg::DATA_W-1:0] data_in,
    input wire logic [nv_clock_pkg::DATA_W-1:0] data_out,
    input wire logic data_oe_n,
    input wire logic supply_ok,
    input wire logic power_fail_out_n
);
    import nv_clock_pkg::*;
    logic [1:0] age_reg;
    logic [1:0] age_next;
    logic settled;
    // Pins reach the outputs through three flops, so checks wait three edges after reset.
    assign age_next = !resetn ? 2'h0 : ((age_reg == 2'h3) ? age_reg : age_reg + 2'h1);
    assign settled = (age_reg == 2'h3);
    always_ff @(posedge clock) begin
        age_reg <= age_next;
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);
    a_pfo_follows: assert property (settled |-> power_fail_out_n == $past(supply_ok, 3))
        else $error("power fail output does not follow supply");
    a_pfo_drop: assert property (settled && $fell(supply_ok) |-> ##3 !power_fail_out_n)
        else $error("power fail output not low after supply drop");
    a_supply_float: assert property (settled && !$past(supply_ok, 3) |-> data_oe_n)
        else $error("bus driven while supply low");
    a_deselect_float: assert property (settled && $past(chip_enable_n, 3) |-> data_oe_n)
        else $error("bus driven while deselected");
    a_oe_float: assert property (settled && $past(output_enable_n, 3) |-> data_oe_n)
        else $error("bus driven with output enable high");
    a_write_float: assert property (settled && !$past(write_enable_n, 3) |-> data_oe_n)
        else $error("bus driven during write");
    a_read_drive: assert property (settled && !$past(chip_enable_n, 3) &&
        !$past(output_enable_n, 3) && $past(write_enable_n, 3) && $past(supply_ok, 3) |-> !data_oe_n)
        else $error("bus not driven during read");
    a_reset_quiet: assert property (disable iff (1'b0) !resetn |=> data_oe_n && power_fail_out_n && data_out == 8'h00)
        else $error("outputs not quiet in reset");
    c_read: cover property (settled && !data_oe_n);
    c_drop: cover property (settled && $fell(supply_ok));
    c_write: cover property (!chip_enable_n && !write_enable_n);
endmodule
bind nv_timekeeping_ram_clock nv_clock_properties #(.TEST_DIV(TEST_DIV)) u_props (
    .clock(clock), .resetn(resetn), .address(address), .chip_enable_n(chip_enable_n),
    .output_enable_n(output_enable_n), .write_enable_n(write_enable_n), .data_in(data_in),
    .data_out(data_out), .data_oe_n(data_oe_n), .supply_ok(supply_ok),
    .power_fail_out_n(power_fail_out_n));
`default_nettype wire

// >>> tb/nv_clock_host.sv
// Host processor model driving the asynchronous memory pins.
`timescale 1ns/1ps
`default_nettype none
module nv_clock_host (
    // Clock.
    input wire logic clock,
    // Memory bus pins.
    output logic [nv_clock_pkg::ADDR_W-1:0] address,
    output logic chip_enable_n,
    output logic output_enable_n,
    output logic write_enable_n,
    output logic [nv_clock_pkg::DATA_W-1:0] data_in,
    input wire logic [nv_clock_pkg::DATA_W-1:0] data_out,
    input wire logic data_oe_n,
    // Read results.
    output logic got,
    output logic [nv_clock_pkg::DATA_W-1:0] got_data,
    output logic hung
);
    import nv_clock_pkg::*;
    initial begin
        {address, chip_enable_n, output_enable_n, write_enable_n} = {19'h00000, 3'h7};
        {data_in, got, got_data, hung} = 18'h00000;
    end
    task automatic wr(input logic [18:0] a, input logic [7:0] d);
        @(posedge clock);
        address <= a;
        data_in <= d;
        {chip_enable_n, write_enable_n} <= 2'h0;
        repeat (3) @(posedge clock);
        {chip_enable_n, write_enable_n} <= 2'h3;
        // A released bus does not keep its last value.
        data_in <= ~d;
        repeat (4) @(posedge clock);
    endtask
    task automatic rd(input logic [18:0] a, output logic [7:0] v);
        int n;
        open_rd(a);
        n = 0;
        while (data_oe_n !== 1'b0 && n < 10) begin
            @(posedge clock);
            n++;
        end
        hung <= (n == 10);
        v = data_out;
        got <= 1'b1;
        got_data <= data_out;
        @(posedge clock);
        got <= 1'b0;
        close_rd();
    endtask
    task automatic open_rd(input logic [18:0] a);
        @(posedge clock);
        address <= a;
        {chip_enable_n, output_enable_n} <= 2'h0;
    endtask
    task automatic close_rd();
        {chip_enable_n, output_enable_n} <= 2'h3;
        repeat (4) @(posedge clock);
    endtask
endmodule
`default_nettype wire

// >>> tb/nv_timekeeping_ram_clock_bench.sv
// Self-checking bench for the timekeeping memory.
`timescale 1ns/1ps
`default_nettype none
module nv_timekeeping_ram_clock_bench;
    import nv_clock_pkg::*;
    localparam logic [18:0] BASE = 19'h7fff8;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic supply_ok = 1'b1;
    logic [18:0] address;
    logic chip_enable_n, output_enable_n, write_enable_n, data_oe_n, power_fail_out_n, got, hung;
    logic [7:0] data_in, data_out, got_data, v, d;
    logic [7:0] exp_q[$];
    logic [31:0] seed = 32'h48e9;
    logic p;
    int error_cnt = 0;
    int cmp_count = 0;
    int tg;
    always #12.5 clock = ~clock;
    nv_timekeeping_ram_clock #(.TEST_DIV(4)) u_nv_timekeeping_ram_clock (.clock(clock),
        .resetn(resetn), .address(address), .chip_enable_n(chip_enable_n),
        .output_enable_n(output_enable_n), .write_enable_n(write_enable_n), .data_in(data_in),
        .data_out(data_out), .data_oe_n(data_oe_n), .supply_ok(supply_ok),
        .power_fail_out_n(power_fail_out_n));
    nv_clock_host u_nv_clock_host (.clock(clock), .address(address),
        .chip_enable_n(chip_enable_n), .output_enable_n(output_enable_n),
        .write_enable_n(write_enable_n), .data_in(data_in), .data_out(data_out),
        .data_oe_n(data_oe_n), .got(got), .got_data(got_data), .hung(hung));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        xorshift = x ^ (x << 5);
    endfunction
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic rd_exp(input logic [18:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        u_nv_clock_host.rd(a, v);
    endtask
    // Loads a date under write hold, waits for the next second tick and reads the result.
    task automatic roll(input logic [55:0] ld, input logic [55:0] ex);
        int n;
        u_nv_clock_host.wr(BASE, 8'h80);
        for (int i = 0; i < 7; i++) begin
            u_nv_clock_host.wr(BASE + 19'(i + 1), ld[8*i +: 8]);
        end
        u_nv_clock_host.wr(BASE, 8'h00);
        n = 0;
        v = ld[7:0];
        while (v === ld[7:0] && n < 300) begin
            u_nv_clock_host.rd(BASE + 19'h1, v);
            n++;
        end
        if (n == 300) begin
            error_cnt++;
            give_verdict();
        end
        for (int i = 0; i < 7; i++) begin
            rd_exp(BASE + 19'(i + 1), ex[8*i +: 8]);
        end
        $display("date roll done");
    endtask
    always @(posedge clock) begin
        if (hung === 1'b1) begin
            error_cnt++;
            give_verdict();
        end
        if (got === 1'b1 && exp_q.size() > 0) begin
            check("read data", got_data, exp_q.pop_front());
        end
    end
    initial begin
        repeat (4) @(posedge clock);
        resetn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rd_exp(BASE + 19'(i), (i >= 4 && i <= 6) ? 8'h01 : 8'h00);
        end
        for (int i = 0; i < 4; i++) begin
            seed = xorshift(seed);
            u_nv_clock_host.wr(i == 3 ? 19'h7fff7 : {1'b0, seed[17:0]}, seed[26:19]);
            rd_exp(i == 3 ? 19'h7fff7 : {1'b0, seed[17:0]}, seed[26:19]);
        end
        $display("memory test done");
        d = seed[7:0];
        u_nv_clock_host.wr(19'h00005, d);
        supply_ok <= 1'b0;
        u_nv_clock_host.wr(19'h00005, ~d);
        check("power fail low", {7'h00, power_fail_out_n}, 8'h00);
        supply_ok <= 1'b1;
        repeat (4) @(posedge clock);
        check("power fail high", {7'h00, power_fail_out_n}, 8'h01);
        rd_exp(19'h00005, d);
        $display("supply test done");
        roll(56'h99123107235959, 56'h00010101000000);
        u_nv_clock_host.wr(BASE, 8'h40);
        repeat (5000) @(posedge clock);
        rd_exp(BASE + 19'h1, 8'h00);
        u_nv_clock_host.wr(BASE, 8'h00);
        repeat (2000) @(posedge clock);
        rd_exp(BASE + 19'h1, 8'h03);
        $display("read hold done");
        roll(56'h04022803235959, 56'h04022904000000);
        roll(56'h01e22803235959, 56'h01e30104000000);
        u_nv_clock_host.wr(BASE + 19'h4, 8'h41);
        u_nv_clock_host.open_rd(BASE + 19'h1);
        repeat (6) @(posedge clock);
        p = data_out[0];
        tg = 0;
        repeat (64) begin
            @(posedge clock);
            tg += (data_out[0] !== p);
            p = data_out[0];
        end
        u_nv_clock_host.close_rd();
        check("test toggles", {7'h00, tg >= 15 && tg <= 17}, 8'h01);
        $display("frequency test done");
        u_nv_clock_host.wr(BASE + 19'h1, 8'h85);
        repeat (2500) @(posedge clock);
        rd_exp(BASE + 19'h1, 8'h85);
        roll(56'h00010101000005, 56'h00010101000006);
        $display("oscillator halt done");
        give_verdict();
    end
endmodule
`default_nettype wire
